//--- verilog/msp_pkg.sv
// Constants shared by the multidrop serial port and its oscillator link.
// Assumes a 25 MHz system clock and a reference clock for the link side.
package msp_pkg;

  // ************************************************************
  // Frame layout
  // ************************************************************
  localparam int        DATA_BITS    = 24;
  localparam int        NUM_REGS     = 32;
  localparam int        OSC_PKT_BITS = 16;
  localparam logic [5:0] FRAME_LAST  = 6'h20;
  localparam logic [2:0] CHIP_ADDR_OWN = 3'h0;

  // ************************************************************
  // Register indices
  // ************************************************************
  localparam logic [4:0] REG_READ_ADDR    = 5'h00;
  localparam logic [4:0] REG_SPARE        = 5'h01;
  localparam logic [4:0] REG_REF_DIV      = 5'h02;
  localparam logic [4:0] REG_FREQ_INT     = 5'h03;
  localparam logic [4:0] REG_FREQ_FRAC    = 5'h04;
  localparam logic [4:0] REG_OSC_INDIRECT = 5'h05;
  localparam logic [4:0] REG_MOD_CFG      = 5'h06;
  localparam logic [4:0] REG_PUMP         = 5'h09;
  localparam logic [4:0] REG_LINK_RATE    = 5'h0a;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int SOFT_RESET_BIT = 5;
  localparam int RATE_LSB       = 13;
  localparam int PKT_ID_LSB     = 0;
  localparam int PKT_REG_LSB    = 3;
  localparam int PKT_DATA_LSB   = 7;
  localparam logic [23:0] OSC_MASK = 24'h00ffff;

  // ************************************************************
  // Values after reset
  // ************************************************************
  localparam logic [23:0] RST_SPARE     = 24'h000002;
  localparam logic [23:0] RST_REF_DIV   = 24'h000001;
  localparam logic [23:0] RST_FREQ_INT  = 24'h000019;
  localparam logic [23:0] RST_MOD_CFG   = 24'h200b4a;
  localparam logic [23:0] RST_LINK_RATE = 24'h002000;

  typedef enum logic [1:0] {
    LINK_IDLE  = 2'b00,
    LINK_SHIFT = 2'b01,
    LINK_END   = 2'b10
  } msp_link_state_t;

  function automatic logic [23:0] msp_reset_value(input int idx);
    case (idx)
      1:       return RST_SPARE;
      2:       return RST_REF_DIV;
      3:       return RST_FREQ_INT;
      6:       return RST_MOD_CFG;
      10:      return RST_LINK_RATE;
      default: return 24'h000000;
    endcase
  endfunction : msp_reset_value

endpackage : msp_pkg

//--- verilog/msp_link_if.sv
// Carrier between the serial port core and the oscillator link sender.
// The core side runs on the system clock, the link side on the reference.
`timescale 1ns/100ps
interface msp_link_if;
  logic [15:0] packet;
  logic        reqToggle;
  logic        ackToggle;
  logic [1:0]  rate;

  modport main (
    output packet,
    output reqToggle,
    output rate,
    input  ackToggle
  );

  modport link (
    input  packet,
    input  reqToggle,
    input  rate,
    output ackToggle
  );
endinterface : msp_link_if

//--- verilog/msp_pin_sync.sv
// Two flip-flop synchroniser, one per bit.
// Inputs are levels from another clock domain or from pins.
`timescale 1ns/100ps
module msp_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // Levels
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] sync
);
  logic [WIDTH-1:0] stage1;

  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        stage1[i] <= 1'b0;
        sync[i]   <= 1'b0;
      end else begin
        stage1[i] <= async[i];
        sync[i]   <= stage1[i];
      end
    end
  end
endmodule : msp_pin_sync

//--- verilog/msp_osc_link_tx.sv
// Oscillator link sender: shifts one 16-bit packet out per request.
// Runs on the reference clock; the request arrives as a toggle.
`timescale 1ns/100ps
module msp_osc_link_tx (
  // Link clock and reset
  input  wire logic  linkClock,
  input  wire logic  resetn,
  // Request side
  msp_link_if.link   bus,
  // Link pins
  output logic       oscLinkClock,
  output logic       oscLinkData,
  output logic       oscLinkEnable
);
  logic [2:0]              linkSync;
  logic                    reqSeen;
  logic [3:0]              divCnt;
  logic [3:0]              bitCnt;
  logic [15:0]             shreg;
  logic [1:0]              rateHold;
  msp_pkg::msp_link_state_t state;

  // Rate is latched with each request, so a change never bends a packet
  msp_pin_sync #(.WIDTH(3)) u_sync (
    .clock  (linkClock),
    .resetn (resetn),
    .async  ({bus.rate, bus.reqToggle}),
    .sync   (linkSync)
  );

  wire       reqNew    = linkSync[0] ^ reqSeen;
  wire [3:0] halfLimit = 4'h1 << rateHold;
  wire       tick      = (divCnt == 4'(halfLimit - 4'h1));

  always_ff @(posedge linkClock or negedge resetn) begin
    if (!resetn) begin
      divCnt <= 4'h0;
    end else if (state == msp_pkg::LINK_IDLE || tick) begin
      divCnt <= 4'h0;
    end else begin
      divCnt <= 4'(divCnt + 4'h1);
    end
  end

  always_ff @(posedge linkClock or negedge resetn) begin
    if (!resetn) begin
      state         <= msp_pkg::LINK_IDLE;
      reqSeen       <= 1'b0;
      bus.ackToggle <= 1'b0;
      shreg         <= 16'h0000;
      rateHold      <= 2'h1;
      bitCnt        <= 4'h0;
      oscLinkClock  <= 1'b0;
      oscLinkData   <= 1'b0;
      oscLinkEnable <= 1'b0;
    end else begin
      case (state)
        msp_pkg::LINK_IDLE: begin
          if (reqNew) begin
            reqSeen       <= linkSync[0];
            rateHold      <= linkSync[2:1];
            shreg         <= bus.packet;
            oscLinkData   <= bus.packet[15];
            oscLinkEnable <= 1'b1;
            bitCnt        <= 4'h0;
            state         <= msp_pkg::LINK_SHIFT;
          end
        end
        msp_pkg::LINK_SHIFT: begin
          if (tick) begin
            oscLinkClock <= ~oscLinkClock;
            if (oscLinkClock) begin
              if (bitCnt == 4'hf) begin
                state <= msp_pkg::LINK_END;
              end else begin
                shreg       <= {shreg[14:0], 1'b0};
                oscLinkData <= shreg[14];
                bitCnt      <= 4'(bitCnt + 4'h1);
              end
            end
          end
        end
        msp_pkg::LINK_END: begin
          if (tick) begin
            oscLinkEnable <= 1'b0;
            oscLinkData   <= 1'b0;
            bus.ackToggle <= ~bus.ackToggle;
            state         <= msp_pkg::LINK_IDLE;
          end
        end
        default: begin
          state <= msp_pkg::LINK_IDLE;
        end
      endcase
    end
  end
endmodule : msp_osc_link_tx

//--- verilog/msp_serial_port.sv
// Multidrop serial control port with register file and oscillator link.
// Serial pins are asynchronous and are oversampled by the system clock,
// so the serial clock must run well below a quarter of clock.
//
// Behaviour
// - 24 data bits shift in MSB first on the first 24 rising edges.
// - Next 5 rising edges shift in the target register address.
// - Last 3 rising edges shift in the chip address, MSB first.
// - Chip address 000 selects this device.
// - Data is committed to the register on the strobe rising edge.
// - Each frame drives out the register picked by the read address.
// - The read-back frame shifts in 32 more bits while data goes out.
// - During a frame the shared pin carries data, not lock state.
// - The strobe rise ends the frame and restores lock on the pin.
// - Each 05h write sends its 16 bits MSB first over the link.
// - Link rate field in 0Ah defaults to 1, reference divided by 4.
// - Packet carries id in 2:0, address in 6:3, data in 15:7.
// - A clock edge before any strobe edge fixes this protocol.
// - Register 0 write sets the read address; bit 5 resets it to 0.
`timescale 1ns/100ps
module msp_serial_port #(
  parameter logic [23:0] CHIP_ID = 24'h000123 // Arbitrary value
) (
  // System clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // Link clock
  input  wire logic referenceClockIn,
  // Serial port pins
  input  wire logic frameStrobe,
  input  wire logic serialClock,
  input  wire logic serialIn,
  output logic      lockOrSerialOut,
  // Lock state
  input  wire logic lockIndicator,
  // Protocol status
  output logic      openModeActive,
  // Oscillator link
  output logic      oscLinkClock,
  output logic      oscLinkData,
  output logic      oscLinkEnable
);

  // ************************************************************
  // Pin sampling
  // ************************************************************
  logic [3:0] pinSync;
  logic       sclkPrev;
  logic       strobePrev;

  msp_pin_sync #(.WIDTH(4)) u_pin_sync (
    .clock  (clock),
    .resetn (resetn),
    .async  ({lockIndicator, frameStrobe, serialIn, serialClock}),
    .sync   (pinSync)
  );

  wire sclkS   = pinSync[0];
  wire sdiS    = pinSync[1];
  wire strobeS = pinSync[2];
  wire lockS   = pinSync[3];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sclkPrev   <= 1'b0;
      strobePrev <= 1'b0;
    end else begin
      sclkPrev   <= sclkS;
      strobePrev <= strobeS;
    end
  end

  wire sclkRise   = sclkS & ~sclkPrev;
  wire strobeRise = strobeS & ~strobePrev;

  // ************************************************************
  // Protocol decision
  // ************************************************************
  logic modeDecided;
  logic openMode;

  // A strobe edge in the same sample as the first clock edge wins
  wire openNow    = modeDecided ? openMode : (sclkRise & ~strobeRise);
  wire sclkTake   = sclkRise & openNow;
  wire strobeTake = strobeRise & modeDecided & openMode;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      modeDecided <= 1'b0;
      openMode    <= 1'b0;
    end else if (!modeDecided && (sclkRise || strobeRise)) begin
      modeDecided <= 1'b1;
      openMode    <= ~strobeRise;
    end
  end

  // ************************************************************
  // Frame shifter
  // ************************************************************
  logic [5:0]  bitCnt;
  logic [31:0] shiftReg;

  wire [23:0] shiftData = shiftReg[31:8];
  wire [4:0]  shiftAddr = shiftReg[7:3];
  wire [2:0]  shiftChip = shiftReg[2:0];
  wire        frameFull = (bitCnt == msp_pkg::FRAME_LAST);
  wire        chipMatch = (shiftChip == msp_pkg::CHIP_ADDR_OWN);
  wire        writeEn   = strobeTake & frameFull & chipMatch;
  wire        regZeroWr = writeEn & (shiftAddr == msp_pkg::REG_READ_ADDR);
  wire        softReset = regZeroWr & shiftData[msp_pkg::SOFT_RESET_BIT];
  wire        oscWrite  = writeEn & (shiftAddr == msp_pkg::REG_OSC_INDIRECT);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bitCnt <= 6'h00;
    end else if (strobeTake) begin
      bitCnt <= 6'h00;
    end else if (sclkTake && !frameFull) begin
      bitCnt <= 6'(bitCnt + 6'h01);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      shiftReg <= 32'h00000000;
    end else if (sclkTake) begin
      shiftReg <= {shiftReg[30:0], sdiS};
    end
  end

  // ************************************************************
  // Register file
  // ************************************************************
  logic [23:0] regFile [msp_pkg::NUM_REGS];
  logic [4:0]  readAddr;

  genvar r;
  for (r = 0; r < msp_pkg::NUM_REGS; r++) begin : g_reg
    localparam logic [23:0] MASK =
      (r == int'(msp_pkg::REG_OSC_INDIRECT)) ? msp_pkg::OSC_MASK
                                             : 24'hffffff;
    wire hit = writeEn && (r != 0) && (shiftAddr == 5'(r));
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        regFile[r] <= msp_pkg::msp_reset_value(r);
      end else if (hit) begin
        regFile[r] <= shiftData & MASK;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      readAddr <= 5'h00;
    end else if (softReset) begin
      readAddr <= 5'h00;
    end else if (regZeroWr) begin
      readAddr <= shiftData[4:0];
    end
  end

  wire [23:0] readWord = (readAddr == msp_pkg::REG_READ_ADDR) ? CHIP_ID
                                                           : regFile[readAddr];

  // ************************************************************
  // Read-back path
  // ************************************************************
  logic        frameActive;
  logic        loadPending;
  logic [23:0] outShift;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      frameActive <= 1'b0;
      loadPending <= 1'b1;
    end else begin
      loadPending <= strobeTake;
      if (strobeTake) begin
        frameActive <= 1'b0;
      end else if (sclkTake) begin
        frameActive <= 1'b1;
      end
    end
  end

  // Reload waits one cycle so a new read address is already in place
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      outShift <= 24'h000000;
    end else if (loadPending) begin
      outShift <= readWord;
    end else if (sclkTake && frameActive) begin
      outShift <= {outShift[22:0], 1'b0};
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lockOrSerialOut <= 1'b0;
      openModeActive  <= 1'b0;
    end else begin
      lockOrSerialOut <= frameActive ? outShift[23] : lockS;
      openModeActive  <= modeDecided & openMode;
    end
  end

  // ************************************************************
  // Oscillator link request
  // ************************************************************
  msp_link_if linkBus ();

  logic        pending;
  logic        busy;
  logic        reqToggle;
  logic        ackSeen;
  logic        ackSync;
  logic [15:0] pktHold;

  // Packet stays frozen until the ack returns, so words cross safely
  wire launch = pending & ~busy;
  wire ackNew = ackSync ^ ackSeen;

  msp_pin_sync #(.WIDTH(1)) u_ack_sync (
    .clock  (clock),
    .resetn (resetn),
    .async  (linkBus.ackToggle),
    .sync   (ackSync)
  );

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pending   <= 1'b0;
      busy      <= 1'b0;
      reqToggle <= 1'b0;
      ackSeen   <= 1'b0;
      pktHold   <= 16'h0000;
    end else begin
      pending <= oscWrite | (pending & ~launch);
      ackSeen <= ackSync;
      if (launch) begin
        busy      <= 1'b1;
        reqToggle <= ~reqToggle;
        pktHold   <= regFile[msp_pkg::REG_OSC_INDIRECT][15:0];
      end else if (ackNew) begin
        busy <= 1'b0;
      end
    end
  end

  assign linkBus.packet    = pktHold;
  assign linkBus.reqToggle = reqToggle;
  assign linkBus.rate      =
    regFile[msp_pkg::REG_LINK_RATE][msp_pkg::RATE_LSB +: 2];

  msp_osc_link_tx u_link (
    .linkClock     (referenceClockIn),
    .resetn        (resetn),
    .bus           (linkBus.link),
    .oscLinkClock  (oscLinkClock),
    .oscLinkData   (oscLinkData),
    .oscLinkEnable (oscLinkEnable)
  );

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  property p_bit_count;
    sclkTake && !strobeTake && !frameFull |=>
      bitCnt == 6'($past(bitCnt) + 6'h01) && shiftReg[0] == $past(sdiS);
  endproperty
  a_bit_count: assert property (p_bit_count)
    else $error("bit counter or shifter missed a clock edge");

  property p_int_commit;
    writeEn && shiftAddr == msp_pkg::REG_FREQ_INT |=>
      regFile[msp_pkg::REG_FREQ_INT] == $past(shiftData);
  endproperty
  a_int_commit: assert property (p_int_commit)
    else $error("addressed register not written with frame data");

  property p_foreign;
    strobeTake && !chipMatch |=>
      $stable(regFile[msp_pkg::REG_FREQ_FRAC]) && $stable(readAddr);
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("frame for another chip changed state");

  property p_write_gate;
    writeEn |-> chipMatch && frameFull && $rose(strobeS);
  endproperty
  a_write_gate: assert property (p_write_gate)
    else $error("write without full frame, own chip or strobe edge");

  property p_no_early_write;
    sclkTake && !strobeTake |=> $stable(regFile[msp_pkg::REG_FREQ_FRAC]);
  endproperty
  a_no_early_write: assert property (p_no_early_write)
    else $error("register changed during shifting");

  property p_load_out;
    loadPending |=> outShift == $past(readWord);
  endproperty
  a_load_out: assert property (p_load_out)
    else $error("read-back word not loaded");

  property p_readback;
    frameActive |=> lockOrSerialOut == $past(outShift[23]);
  endproperty
  a_readback: assert property (p_readback)
    else $error("shared pin not carrying read data in frame");

  property p_lock_restore;
    strobeTake |-> ##2 lockOrSerialOut == $past(lockS);
  endproperty
  a_lock_restore: assert property (p_lock_restore)
    else $error("lock state not restored after strobe");

  property p_forward;
    oscWrite |=> pending ##[1:3] busy;
  endproperty
  a_forward: assert property (p_forward)
    else $error("oscillator register write not forwarded");

  property p_read_addr;
    regZeroWr && !softReset |=> readAddr == $past(shiftData[4:0]);
  endproperty
  a_read_addr: assert property (p_read_addr)
    else $error("read address not taken from register 0 write");

  property p_mode_fixed;
    modeDecided |=> modeDecided && $stable(openMode);
  endproperty
  a_mode_fixed: assert property (p_mode_fixed)
    else $error("protocol choice changed after decision");

  property p_c_write;
    writeEn && shiftAddr == msp_pkg::REG_FREQ_INT;
  endproperty
  c_write: cover property (p_c_write);

  property p_c_read;
    frameActive && readAddr != msp_pkg::REG_READ_ADDR;
  endproperty
  c_read: cover property (p_c_read);

  property p_c_link;
    busy && ackNew;
  endproperty
  c_link: cover property (p_c_link);

  property p_c_open;
    $rose(openModeActive);
  endproperty
  c_open: cover property (p_c_open);

endmodule : msp_serial_port

//--- verif/msp_host_model.sv
// Host serial master model that drives frames into the serial port.
// Assumes the system clock paces it; all pin changes land on its fall.
`timescale 1ns/100ps
module msp_host_model (
  // Pacing clock
  input  wire logic clock,
  // Serial pins
  output logic      frameStrobe,
  output logic      serialClock,
  output logic      serialIn,
  input  wire logic lockOrSerialOut
);
  initial begin
    frameStrobe = 1'b0;
    serialClock = 1'b0;
    serialIn    = 1'b0;
  end

  task automatic waitc(input int n);
    repeat (n) @(negedge clock);
  endtask : waitc

  // ************************************************************
  // One frame; the serial clock stays low outside it
  // ************************************************************
  // Slow edges: the port oversamples pins, so each phase spans 6 clocks
  task automatic frame(input logic [31:0] word, input int n,
                       output logic [23:0] readBack);
    readBack = 24'h000000;
    for (int i = 0; i < n; i++) begin
      serialIn = word[31-i];
      waitc(6);
      serialClock = 1'b1;
      waitc(6);
      serialClock = 1'b0;
      waitc(5);
      if (i < 24) readBack = {readBack[22:0], lockOrSerialOut};
      waitc(1);
    end
    waitc(4);
    frameStrobe = 1'b1;
    serialIn    = ~serialIn;
    waitc(6);
    frameStrobe = 1'b0;
    waitc(8);
  endtask : frame
endmodule : msp_host_model

//--- verif/msp_serial_port_tb.sv
// Self-checking bench for the multidrop serial port and its link.
// Assumes the host model and a free-running 32 ns reference clock.
`timescale 1ns/100ps
module msp_serial_port_tb;
  localparam int          LIMIT  = 60000;
  localparam logic [23:0] ID_VAL = 24'h000123; // Arbitrary value

  logic        clock, resetn, referenceClockIn, lockIndicator;
  logic        frameStrobe, serialClock, serialIn, lockOrSerialOut;
  logic        openModeActive, oscLinkClock, oscLinkData, oscLinkEnable;
  int          failures, samples_checked, cycles, linkBits;
  logic [15:0] linkWord;
  realtime     lastRise, linkPeriod;

  msp_serial_port #(.CHIP_ID(ID_VAL)) msp_serial_port_inst (
    .clock(clock), .resetn(resetn), .referenceClockIn(referenceClockIn),
    .frameStrobe(frameStrobe), .serialClock(serialClock),
    .serialIn(serialIn), .lockOrSerialOut(lockOrSerialOut),
    .lockIndicator(lockIndicator), .openModeActive(openModeActive),
    .oscLinkClock(oscLinkClock), .oscLinkData(oscLinkData),
    .oscLinkEnable(oscLinkEnable));

  msp_host_model msp_host_model_inst (
    .clock(clock), .frameStrobe(frameStrobe), .serialClock(serialClock),
    .serialIn(serialIn), .lockOrSerialOut(lockOrSerialOut));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Phase offset keeps the link clock unrelated to the system clock
  initial begin
    referenceClockIn = 1'b0;
    #7;
    forever #16 referenceClockIn = ~referenceClockIn;
  end

  // Link bits are taken where the receiver samples them
  always @(posedge oscLinkClock) begin
    if (oscLinkEnable === 1'b1) begin
      linkWord   = {linkWord[14:0], oscLinkData};
      linkBits   = linkBits + 1;
      linkPeriod = $realtime - lastRise;
      lastRise   = $realtime;
    end
  end

  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      failures = failures + 1;
      $display("MISMATCH %0t run did not finish in time", $time);
      end_sim();
    end
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic end_sim();
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic chkWord(input logic [23:0] got, input logic [23:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("MISMATCH %0t word got %h exp %h", $time, got, exp);
    end
  endtask : chkWord

  task automatic chkBit(input logic got, input logic exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("MISMATCH %0t bit got %b exp %b", $time, got, exp);
    end
  endtask : chkBit

  function automatic logic [31:0] fw(input logic [23:0] d,
                                     input logic [4:0] a,
                                     input logic [2:0] c);
    return {d, a, c};
  endfunction : fw

  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    logic [23:0] dummy;
    msp_host_model_inst.frame(fw(d, a, 3'h0), 32, dummy);
  endtask : wr

  // Second frame resends the same register 0 write
  task automatic rdReg(input logic [4:0] a, output logic [23:0] d);
    wr(5'h00, {19'h00000, a});
    msp_host_model_inst.frame(fw({19'h00000, a}, 5'h00, 3'h0), 32, d);
  endtask : rdReg

  task automatic waitLink(input int n);
    int k;
    k = 0;
    while (!(linkBits == n && oscLinkEnable === 1'b0) && k < 400) begin
      @(negedge clock);
      k++;
    end
  endtask : waitLink

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_first_frame();
    logic [23:0] d;
    chkBit(openModeActive, 1'b0);
    lockIndicator = 1'b1;
    repeat (6) @(negedge clock);
    chkBit(lockOrSerialOut, 1'b1);
    msp_host_model_inst.frame(fw(24'h000000, 5'h00, 3'h0), 32, d);
    chkWord(d, ID_VAL);
    chkBit(openModeActive, 1'b1);
    chkBit(lockOrSerialOut, 1'b1);
  endtask : t_first_frame

  task automatic t_reset_values();
    logic [4:0]  regs [5] = '{5'h01, 5'h02, 5'h03, 5'h06, 5'h0a};
    logic [23:0] vals [5] = '{msp_pkg::RST_SPARE, msp_pkg::RST_REF_DIV,
      msp_pkg::RST_FREQ_INT, msp_pkg::RST_MOD_CFG, msp_pkg::RST_LINK_RATE};
    logic [23:0] d;
    for (int i = 0; i < 5; i++) begin
      lockIndicator = i[0];
      rdReg(regs[i], d);
      chkWord(d, vals[i]);
      chkBit(lockOrSerialOut, i[0]);
    end
  endtask : t_reset_values

  task automatic t_write_read();
    logic [23:0] d;
    wr(5'h03, 24'h0a5c3f);
    wr(5'h04, 24'hf0f0f1);
    msp_host_model_inst.frame(fw(24'h555555, 5'h03, 3'h0), 31, d);
    rdReg(5'h03, d);
    chkWord(d, 24'h0a5c3f);
    msp_host_model_inst.frame(fw(24'h111111, 5'h03, 3'h0), 32, d);
    chkWord(d, 24'h0a5c3f);
    msp_host_model_inst.frame(fw(24'h222222, 5'h03, 3'h5), 32, d);
    chkWord(d, 24'h111111);
    msp_host_model_inst.frame(fw(24'h000003, 5'h00, 3'h0), 32, d);
    chkWord(d, 24'h111111);
    rdReg(5'h04, d);
    chkWord(d, 24'hf0f0f1);
  endtask : t_write_read

  task automatic t_soft_reset();
    logic [23:0] d;
    msp_host_model_inst.frame(fw(24'h000027, 5'h00, 3'h0), 32, d);
    chkWord(d, 24'hf0f0f1);
    msp_host_model_inst.frame(fw(24'h000000, 5'h00, 3'h5), 32, d);
    chkWord(d, ID_VAL);
  endtask : t_soft_reset

  task automatic t_link();
    logic [4:0]  regs [7] = '{5'h02, 5'h06, 5'h09, 5'h05, 5'h03, 5'h04,
                              5'h05};
    logic [23:0] vals [7] = '{24'h000001, msp_pkg::RST_MOD_CFG, 24'h3c3c3c,
      24'h000a10, 24'h00001c, 24'h000abc, 24'hab7f10};
    logic [23:0] d;
    for (int i = 0; i < 7; i++) wr(regs[i], vals[i]);
    waitLink(32);
    chkWord(24'(linkBits), 24'd32);
    chkWord({8'h00, linkWord}, {8'h00, 9'h0fe, 4'h2, 3'h0});
    chkBit(linkPeriod == 128.0, 1'b1);
    chkBit(oscLinkClock, 1'b0);
    rdReg(5'h09, d);
    chkWord(d, 24'h3c3c3c);
    rdReg(5'h05, d);
    chkWord(d, 24'hab7f10 & msp_pkg::OSC_MASK);
    wr(5'h0a, 24'h004000);
    wr(5'h05, 24'h000321);
    waitLink(48);
    chkWord({8'h00, linkWord}, 24'h000321);
    chkBit(linkPeriod == 256.0, 1'b1);
  endtask : t_link

  // Strobe before any serial clock after reset leaves the port dead
  task automatic t_legacy();
    logic [23:0] d;
    resetn        = 1'b0;
    lockIndicator = 1'b1;
    repeat (4) @(negedge clock);
    resetn = 1'b1;
    repeat (4) @(negedge clock);
    chkBit(openModeActive, 1'b0);
    msp_host_model_inst.frame(32'h00000000, 0, d);
    msp_host_model_inst.frame(fw(24'h000000, 5'h00, 3'h0), 32, d);
    chkWord(d, 24'hffffff);
    chkBit(openModeActive, 1'b0);
  endtask : t_legacy

  initial begin
    resetn          = 1'b0;
    lockIndicator   = 1'b0;
    failures        = 0;
    samples_checked = 0;
    cycles          = 0;
    linkBits        = 0;
    linkWord        = 16'h0000;
    lastRise        = 0.0;
    linkPeriod      = 0.0;
    repeat (20) @(negedge clock);
    resetn = 1'b1;
    repeat (4) @(negedge clock);
    t_first_frame();
    t_reset_values();
    t_write_read();
    t_soft_reset();
    t_link();
    t_legacy();
    end_sim();
  end
endmodule : msp_serial_port_tb
